// ===== hcr_defines.svh
// constants for the host config and timeout register bank
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH
`define HCR_OFF_IER        8'h24
`define HCR_OFF_TX_DMA_CONFIG      8'h30
`define HCR_OFF_RX_DMA_CONFIG      8'h34
`define HCR_OFF_JLA        8'h38
`define HCR_OFF_STATS      8'h40
`define HCR_OFF_TIMEOUT_PRESCALE       8'h44
`define HCR_OFF_RX_IDLE_TIMEOUT       8'h48
`define HCR_OFF_TX_IDLE_TIMEOUT       8'h4c
`define HCR_OFF_GAP        8'h50
`define HCR_OFF_CNT        8'h54
`define HCR_OFF_OBS        8'h58
`define HCR_OFF_AWAKE      8'h5c
`define HCR_OFF_ASLEEP     8'h60
`define HCR_RST_TX_DMA_CONFIG      32'h00000015
`define HCR_RST_RX_DMA_CONFIG      8'h05
`define HCR_RST_STATS      2'h3
`define HCR_RST_GAP        10'h01f
`define HCR_RST_CNT        5'h1f
`define HCR_RST_ASLEEP_COUNT   24'h00001f
`define HCR_CNT_OFF        5'h1f
`define HCR_WAKE_UNIT      8'hff
`define HCR_JUMBO_SHIFT    12
`define HCR_PHYERR_CHIRP   8'h08
`define HCR_PHYERR_DCHIRP  8'h03
`define HCR_ZLF_NONE       2'h0
`define HCR_ZLF_CHIRP      2'h1
`define HCR_ZLF_ALL        2'h2
`define HCR_BURST_MIN      10'h004
`endif

// ===== hcr_pkg.sv
// types for the host config and timeout register bank
package hcr_pkg;
   typedef struct packed {
      logic       cache_disable;
      logic       double_buffer_disable;
      logic       slow_clock_schedule_disable;
      logic       peer_fragment_burst_policy;
      logic       peer_beacon_window_policy;
      logic       tx_large_descriptor_mode;
      logic [5:0] tx_trigger_level;
      logic [2:0] master_read_burst_size;
   } hcr_tx_cfg_t;
   typedef struct packed {
      logic       sleep_with_pending_rx;
      logic       rx_large_buffer_wrap;
      logic       rx_large_descriptor_mode;
      logic [1:0] zero_length_frame_policy;
      logic [2:0] master_write_burst_size;
   } hcr_rx_cfg_t;
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] phy_err_code;
      logic       is_chirp;
      logic       is_double_chirp;
   } hcr_zlf_t;
endpackage

// ===== hcr_regs.sv
// host interface config, timeout and sleep counter register bank
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "hcr_defines.svh"
module hcr_regs (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   input  wire logic                 irq_pending,
   output logic                      irq_out,
   output hcr_pkg::hcr_tx_cfg_t      tx_cfg,
   output hcr_pkg::hcr_rx_cfg_t      rx_cfg,
   output logic [9:0]                read_burst_bytes,
   output logic [9:0]                write_burst_bytes,
   output logic [11:0]               tx_trigger_bytes,
   input  wire logic [15:0]          tx_buf_len,
   output logic [27:0]               tx_buf_len_eff,
   input  wire logic [15:0]          rx_buf_len,
   output logic [27:0]               rx_buf_len_eff,
   input  wire logic                 rx_buffer_end,
   output logic                      rx_repeat_buffer,
   input  wire logic [9:0]           queue_non_asap_req,
   output logic [9:0]                queue_non_asap_allow,
   output logic                      beacon_cancel_at_window_end,
   output logic                      fragment_yield_at_window,
   output logic                      dual_tx_fifo_enable,
   input  wire logic                 zlf_seen,
   input  wire logic                 zlf_chirp,
   input  wire logic                 zlf_double_chirp,
   output logic                      zlf_transfer,
   output logic                      zlf_desc_done,
   output logic                      zlf_desc_phy_err,
   output logic                      zlf_desc_more,
   output logic [7:0]                zlf_desc_err_code,
   input  wire logic                 rx_fifo_has_frames,
   input  wire logic                 sleep_request,
   output logic                      sleep_allow,
   input  wire logic                 rx_word_write,
   input  wire logic [31:0]          rx_word_addr,
   input  wire logic                 counter_at_threshold,
   output logic                      counters_freeze,
   output logic                      counters_clear,
   output logic                      counters_step_strobe,
   input  wire logic                 rx_frame_done,
   input  wire logic [9:0]           tx_queue_done,
   output logic                      rx_idle_irq,
   output logic                      tx_idle_irq,
   output logic                      rx_descriptor_interrupt,
   output logic [3:0]                dma_observe_select,
   output logic [2:0]                misc_observe_select,
   input  wire logic                 sleep_clk_tick,
   input  wire logic                 core_clock_stopped
);
   logic        rst_meta;
   logic        rst_sync_n;
   logic        global_interrupt_enable;
   logic [15:0] prescale;
   logic [15:0] pre_cnt;
   logic        tick;
   logic [9:0]  rx_idle_limit;
   logic [9:0]  tx_idle_limit;
   logic [9:0]  tx_idle_queue_mask;
   logic [9:0]  rx_idle_cnt;
   logic [9:0]  tx_idle_cnt;
   logic [9:0]  rx_gap_limit;
   logic [9:0]  gap_cnt;
   logic        gap_armed;
   logic [4:0]  rx_count_limit;
   logic [4:0]  frame_cnt;
   logic [31:0] last_addr;
   logic [7:0]  sleep_div;
   logic [23:0] awake_count;
   logic [23:0] asleep_count;
   logic [3:0]  pin_meta;
   logic [3:0]  pin_sync;
   logic        rd_awake;
   logic        rd_asleep;
   logic        wake_tick;
   logic        stop_lvl;
   logic        thr_lvl;

   // flags and pulses across sleep clock domain are synchronised first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         pin_meta <= {sleep_clk_tick, core_clock_stopped, counter_at_threshold, irq_pending};
         pin_sync <= pin_meta;
      end
   end

   assign stop_lvl = pin_sync[2];
   assign thr_lvl  = pin_sync[1];

   function automatic logic [9:0] burst_bytes(input logic [2:0] code);
      burst_bytes = `HCR_BURST_MIN << code;
   endfunction

   function automatic logic [27:0] scale_len(input logic [15:0] len, input logic big);
      scale_len = big ? {len, 12'h000} : {12'h000, len};
   endfunction

   // the word has reserved holes at bits 3 and 13 that the struct leaves out
   function automatic hcr_pkg::hcr_tx_cfg_t tx_cfg_of(input logic [31:0] w);
      tx_cfg_of = {w[16:14], w[12:4], w[2:0]};
   endfunction

   function automatic logic [31:0] tx_word_of(input hcr_pkg::hcr_tx_cfg_t c);
      tx_word_of = {15'h0000, c[14:12], 1'b0, c[11:3], 1'b0, c[2:0]};
   endfunction

   // software register writes
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         global_interrupt_enable                <= 1'b0;
         tx_cfg             <= tx_cfg_of(`HCR_RST_TX_DMA_CONFIG);
         rx_cfg             <= `HCR_RST_RX_DMA_CONFIG;
         {counters_clear, counters_freeze} <= `HCR_RST_STATS;
         prescale           <= 16'h0000;
         rx_idle_limit      <= 10'h000;
         tx_idle_limit      <= 10'h000;
         tx_idle_queue_mask <= 10'h000;
         rx_gap_limit       <= `HCR_RST_GAP;
         rx_count_limit     <= `HCR_RST_CNT;
         dma_observe_select <= 4'h0;
         misc_observe_select <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `HCR_OFF_IER:   global_interrupt_enable <= reg_wdata[0];
            `HCR_OFF_TX_DMA_CONFIG: tx_cfg <= tx_cfg_of(reg_wdata);
            `HCR_OFF_RX_DMA_CONFIG: rx_cfg <= reg_wdata[7:0];
            `HCR_OFF_STATS: {counters_clear, counters_freeze} <= reg_wdata[2:1];
            `HCR_OFF_TIMEOUT_PRESCALE:  prescale <= reg_wdata[15:0];
            `HCR_OFF_RX_IDLE_TIMEOUT:  rx_idle_limit <= reg_wdata[9:0];
            `HCR_OFF_TX_IDLE_TIMEOUT: begin
               tx_idle_limit      <= reg_wdata[9:0];
               tx_idle_queue_mask <= reg_wdata[19:10];
            end
            `HCR_OFF_GAP:   rx_gap_limit <= reg_wdata[9:0];
            `HCR_OFF_CNT:   rx_count_limit <= reg_wdata[4:0];
            `HCR_OFF_OBS: begin
               dma_observe_select  <= reg_wdata[8:5];
               misc_observe_select <= reg_wdata[11:9];
            end
            default: ;
         endcase
      end
   end

   // one-shot step pulse, step bit reads back zero
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         counters_step_strobe <= 1'b0;
      else
         counters_step_strobe <= reg_wr && reg_addr == `HCR_OFF_STATS && reg_wdata[3];
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         irq_out <= 1'b0;
      else
         irq_out <= global_interrupt_enable & pin_sync[0];
   end

   // policy decode to the dma and queue logic
   always_comb begin
      read_burst_bytes  = burst_bytes(tx_cfg.master_read_burst_size);
      write_burst_bytes = burst_bytes(rx_cfg.master_write_burst_size);
      tx_trigger_bytes  = {tx_cfg.tx_trigger_level, 6'h00};
      tx_buf_len_eff    = scale_len(tx_buf_len, tx_cfg.tx_large_descriptor_mode);
      rx_buf_len_eff    = scale_len(rx_buf_len, rx_cfg.rx_large_descriptor_mode);
      rx_repeat_buffer  = rx_buffer_end & rx_cfg.rx_large_buffer_wrap;
      beacon_cancel_at_window_end = ~tx_cfg.peer_beacon_window_policy;
      fragment_yield_at_window    = ~tx_cfg.peer_fragment_burst_policy;
      dual_tx_fifo_enable         = ~tx_cfg.double_buffer_disable;
      // software sets the disable bit for slow clocks; only queues 8 and 9 lose non-asap
      queue_non_asap_allow = queue_non_asap_req &
                             {{2{~tx_cfg.slow_clock_schedule_disable}}, 8'hff};
      sleep_allow = sleep_request & (~rx_fifo_has_frames | rx_cfg.sleep_with_pending_rx);
   end

   // zero-length frame handling
   always_comb begin
      case (rx_cfg.zero_length_frame_policy)
         `HCR_ZLF_NONE:  zlf_transfer = 1'b0;
         `HCR_ZLF_CHIRP: zlf_transfer = zlf_seen & (zlf_chirp | zlf_double_chirp);
         `HCR_ZLF_ALL:   zlf_transfer = zlf_seen;
         default:        zlf_transfer = 1'b0;
      endcase
      zlf_desc_done     = zlf_transfer;
      zlf_desc_phy_err  = zlf_transfer & (zlf_chirp | zlf_double_chirp);
      zlf_desc_more     = 1'b0;
      zlf_desc_err_code = zlf_chirp ? `HCR_PHYERR_CHIRP :
                          (zlf_double_chirp ? `HCR_PHYERR_DCHIRP : 8'h00);
   end

   // address of the last written word while rx large mode is on
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         last_addr <= 32'h00000000;
      else if (rx_word_write && rx_cfg.rx_large_descriptor_mode)
         last_addr <= rx_word_addr;
   end

   // timeout prescaler: core clock is 40 or 80 MHz in the real part
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pre_cnt <= 16'h0000;
         tick    <= 1'b0;
      end else if (prescale == 16'h0000) begin
         pre_cnt <= 16'h0000;
         tick    <= 1'b0;
      end else if (pre_cnt >= prescale - 16'h0001) begin
         pre_cnt <= 16'h0000;
         tick    <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 16'h0001;
         tick    <= 1'b0;
      end
   end

   // idle timeouts: reload on a qualifying frame, count down on ticks
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_idle_cnt <= 10'h000;
         rx_idle_irq <= 1'b0;
      end else begin
         rx_idle_irq <= 1'b0;
         if (rx_idle_limit == 10'h000 || rx_frame_done)
            rx_idle_cnt <= rx_idle_limit;
         else if (tick && rx_idle_cnt != 10'h000) begin
            rx_idle_cnt <= rx_idle_cnt - 10'h001;
            rx_idle_irq <= rx_idle_cnt == 10'h001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_idle_cnt <= 10'h000;
         tx_idle_irq <= 1'b0;
      end else begin
         tx_idle_irq <= 1'b0;
         if (tx_idle_limit == 10'h000 || |(tx_queue_done & tx_idle_queue_mask))
            tx_idle_cnt <= tx_idle_limit;
         else if (tick && tx_idle_cnt != 10'h000) begin
            tx_idle_cnt <= tx_idle_cnt - 10'h001;
            tx_idle_irq <= tx_idle_cnt == 10'h001;
         end
      end
   end

   // rx descriptor interrupt from frame gap or frame count
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         gap_cnt   <= 10'h000;
         gap_armed <= 1'b0;
         frame_cnt <= 5'h00;
         rx_descriptor_interrupt <= 1'b0;
      end else begin
         rx_descriptor_interrupt <= 1'b0;
         if (rx_frame_done) begin
            gap_cnt   <= 10'h000;
            gap_armed <= 1'b1;
            if (rx_count_limit != `HCR_CNT_OFF && frame_cnt == rx_count_limit) begin
               frame_cnt <= 5'h00;
               rx_descriptor_interrupt <= 1'b1;
            end else
               frame_cnt <= frame_cnt + 5'h01;
         end else if (gap_armed && tick) begin
            if (gap_cnt >= rx_gap_limit) begin
               gap_armed <= 1'b0;
               frame_cnt <= 5'h00;
               rx_descriptor_interrupt <= 1'b1;
            end else
               gap_cnt <= gap_cnt + 10'h001;
         end
      end
   end

   // sleep performance counters in 256 sleep clock units, cleared by read
   logic tick_prev;
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tick_prev <= 1'b0;
         sleep_div <= 8'h00;
         wake_tick <= 1'b0;
      end else begin
         tick_prev <= pin_sync[3];
         wake_tick <= 1'b0;
         if (pin_sync[3] && !tick_prev) begin
            sleep_div <= sleep_div + 8'h01;
            wake_tick <= sleep_div == `HCR_WAKE_UNIT;
         end
      end
   end

   assign rd_awake  = reg_rd && reg_addr == `HCR_OFF_AWAKE;
   assign rd_asleep = reg_rd && reg_addr == `HCR_OFF_ASLEEP;

   // the stopped count only moves when the core clock really stopped
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         awake_count  <= `HCR_RST_ASLEEP_COUNT;
         asleep_count <= `HCR_RST_ASLEEP_COUNT;
      end else begin
         if (wake_tick && !stop_lvl)
            awake_count <= (rd_awake ? 24'h000000 : awake_count) + 24'h000001;
         else if (rd_awake)
            awake_count <= 24'h000000;
         if (wake_tick && stop_lvl)
            asleep_count <= (rd_asleep ? 24'h000000 : asleep_count) + 24'h000001;
         else if (rd_asleep)
            asleep_count <= 24'h000000;
      end
   end

   // read data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n)
         reg_rdata <= 32'h00000000;
      else if (reg_rd) begin
         case (reg_addr)
            `HCR_OFF_IER:    reg_rdata <= {31'h0, global_interrupt_enable};
            `HCR_OFF_TX_DMA_CONFIG:  reg_rdata <= tx_word_of(tx_cfg);
            `HCR_OFF_RX_DMA_CONFIG:  reg_rdata <= {24'h0, rx_cfg};
            `HCR_OFF_JLA:    reg_rdata <= last_addr;
            `HCR_OFF_STATS:  reg_rdata <= {28'h0, 1'b0, counters_clear, counters_freeze,
                                           thr_lvl};
            `HCR_OFF_TIMEOUT_PRESCALE:   reg_rdata <= {16'h0, prescale};
            `HCR_OFF_RX_IDLE_TIMEOUT:   reg_rdata <= {22'h0, rx_idle_limit};
            `HCR_OFF_TX_IDLE_TIMEOUT:   reg_rdata <= {12'h0, tx_idle_queue_mask, tx_idle_limit};
            `HCR_OFF_GAP:    reg_rdata <= {22'h0, rx_gap_limit};
            `HCR_OFF_CNT:    reg_rdata <= {27'h0, rx_count_limit};
            `HCR_OFF_OBS:    reg_rdata <= {20'h0, misc_observe_select, dma_observe_select, 5'h0};
            `HCR_OFF_AWAKE:  reg_rdata <= {8'h0, awake_count};
            `HCR_OFF_ASLEEP: reg_rdata <= {8'h0, asleep_count};
            default:         reg_rdata <= 32'h00000000;
         endcase
      end else
         reg_rdata <= 32'h00000000;
   end
endmodule
`default_nettype wire

// ===== hcr_unused.sv
// no logic lives in this file

// ===== hcr_regs_monitor.sv
// concurrent checks on the ports of the host config register bank
`timescale 1ns/1ps
`default_nettype none
module hcr_regs_monitor (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire hcr_pkg::hcr_tx_cfg_t tx_cfg,
   input  wire hcr_pkg::hcr_rx_cfg_t rx_cfg,
   input  wire logic [9:0]           read_burst_bytes,
   input  wire logic [9:0]           write_burst_bytes,
   input  wire logic [11:0]          tx_trigger_bytes,
   input  wire logic [15:0]          tx_buf_len,
   input  wire logic [27:0]          tx_buf_len_eff,
   input  wire logic [15:0]          rx_buf_len,
   input  wire logic [27:0]          rx_buf_len_eff,
   input  wire logic [9:0]           queue_non_asap_req,
   input  wire logic [9:0]           queue_non_asap_allow,
   input  wire logic                 beacon_cancel_at_window_end,
   input  wire logic                 dual_tx_fifo_enable,
   input  wire logic                 rx_fifo_has_frames,
   input  wire logic                 sleep_request,
   input  wire logic                 sleep_allow,
   input  wire logic                 zlf_seen,
   input  wire logic                 zlf_chirp,
   input  wire logic                 zlf_double_chirp,
   input  wire logic                 zlf_transfer,
   input  wire logic                 zlf_desc_phy_err,
   input  wire logic                 zlf_desc_more,
   input  wire logic [7:0]           zlf_desc_err_code,
   input  wire logic                 counters_step_strobe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_burst_size: assert property (
      read_burst_bytes == (10'h004 << tx_cfg.master_read_burst_size)
      && write_burst_bytes == (10'h004 << rx_cfg.master_write_burst_size))
      else $error("burst size wrong");
   a_trigger_bytes: assert property (
      tx_trigger_bytes == {tx_cfg.tx_trigger_level, 6'h00}) else $error("trigger bytes wrong");
   a_tx_scale: assert property (
      tx_buf_len_eff == (tx_cfg.tx_large_descriptor_mode ? {tx_buf_len, 12'h000}
      : {12'h000, tx_buf_len})) else $error("tx length scaling wrong");
   a_rx_scale: assert property (
      rx_buf_len_eff == (rx_cfg.rx_large_descriptor_mode ? {rx_buf_len, 12'h000}
      : {12'h000, rx_buf_len})) else $error("rx length scaling wrong");
   a_beacon_policy: assert property (
      beacon_cancel_at_window_end == !tx_cfg.peer_beacon_window_policy)
      else $error("beacon policy wrong");
   a_slow_queue: assert property (
      queue_non_asap_allow == (queue_non_asap_req
      & {{2{!tx_cfg.slow_clock_schedule_disable}}, 8'hff})) else $error("queue gate wrong");
   a_dual_fifo: assert property (
      dual_tx_fifo_enable == !tx_cfg.double_buffer_disable) else $error("fifo mode wrong");
   a_sleep_block: assert property (
      sleep_request && rx_fifo_has_frames && !rx_cfg.sleep_with_pending_rx |-> !sleep_allow)
      else $error("sleep allowed with frames pending");
   a_step_cause: assert property (
      counters_step_strobe |-> $past(reg_wr && reg_addr == 8'h40 && reg_wdata[3]))
      else $error("step strobe without write");
   a_step_single: assert property (
      !(reg_wr && reg_addr == 8'h40 && reg_wdata[3]) |=> !counters_step_strobe)
      else $error("step strobe too long");
   a_zlf_policy: assert property (
      zlf_transfer == (zlf_seen && (rx_cfg.zero_length_frame_policy == 2'h2
      || (rx_cfg.zero_length_frame_policy == 2'h1 && (zlf_chirp || zlf_double_chirp)))))
      else $error("zero length frame policy wrong");
   a_chirp_code: assert property (
      zlf_transfer && zlf_chirp |-> zlf_desc_phy_err && !zlf_desc_more
      && zlf_desc_err_code == 8'h08) else $error("chirp descriptor wrong");
endmodule
bind hcr_regs hcr_regs_monitor u_monitor (
   .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .tx_cfg, .rx_cfg, .read_burst_bytes,
   .write_burst_bytes, .tx_trigger_bytes, .tx_buf_len, .tx_buf_len_eff, .rx_buf_len,
   .rx_buf_len_eff, .queue_non_asap_req, .queue_non_asap_allow, .beacon_cancel_at_window_end,
   .dual_tx_fifo_enable, .rx_fifo_has_frames, .sleep_request, .sleep_allow,
   .zlf_seen, .zlf_chirp, .zlf_double_chirp, .zlf_transfer, .zlf_desc_phy_err,
   .zlf_desc_more, .zlf_desc_err_code, .counters_step_strobe
);
`default_nettype wire

// ===== hcr_host_model.sv
// host software model driving the register port
`timescale 1ns/1ps
`default_nettype none
module hcr_host_model (
   input  wire logic        clk,
   input  wire logic [31:0] reg_rdata,
   output logic [7:0]       reg_addr,
   output logic [31:0]      reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd
);
   // the slow clock schedule bit is optional at this clock rate, required at 32 mhz or less
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the host config and timeout register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] w;
      logic [31:0] r;
      logic [31:0] e;
   } hcr_row_t;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] cnt = 32'h0;
   logic [7:0]  misc = 8'h00;
   logic [15:0] tx_len = 16'h0000;
   logic [9:0]  q_req = 10'h000;
   logic        irq_pending = 1'b0;
   logic        at_threshold = 1'b0;
   logic        frame_done = 1'b0;
   logic [9:0]  tx_done = 10'h000;
   logic        sleep_tick = 1'b0;
   logic        clock_stopped = 1'b0;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rdv;
   logic        reg_wr, reg_rd, irq_out, step, freeze, clr, rx_irq, tx_irq, desc_irq;
   int          err_total = 0, n_compared = 0, rx_hits = 0, tx_hits = 0, desc_hits = 0;
   // prescale kept small so the timers fire within a few dozen cycles
   hcr_row_t    rows [14] = '{
      '{8'h24, 32'hffffffff, 32'h0, 32'h1}, '{8'h30, 32'hffffffff, 32'h15, 32'h1dff7},
      '{8'h38, 32'hffffffff, 32'h0, 32'h0}, '{8'h34, 32'hffffffff, 32'h5, 32'hff},
      '{8'h40, 32'h0, 32'h6, 32'h0}, '{8'h44, 32'h4, 32'h0, 32'h4},
      '{8'h48, 32'hffffffff, 32'h0, 32'h3ff}, '{8'h4c, 32'hffffffff, 32'h0, 32'hfffff},
      '{8'h50, 32'hffffffff, 32'h1f, 32'h3ff}, '{8'h54, 32'hffffffff, 32'h1f, 32'h1f},
      '{8'h58, 32'hffffffff, 32'hx, 32'hfe0}, '{8'h5c, 32'hffffffff, 32'h1f, 32'h0},
      '{8'h60, 32'hffffffff, 32'h1f, 32'h0}, '{8'h70, 32'hffffffff, 32'h0, 32'h0}};
   hcr_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   hcr_regs DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pending(irq_pending),
      .irq_out(irq_out), .tx_cfg(), .rx_cfg(), .read_burst_bytes(), .write_burst_bytes(),
      .tx_trigger_bytes(), .tx_buf_len(tx_len), .tx_buf_len_eff(), .rx_buf_len(~tx_len),
      .rx_buf_len_eff(), .rx_buffer_end(misc[0]), .rx_repeat_buffer(),
      .queue_non_asap_req(q_req), .queue_non_asap_allow(), .beacon_cancel_at_window_end(),
      .fragment_yield_at_window(), .dual_tx_fifo_enable(), .zlf_seen(misc[1]),
      .zlf_chirp(misc[2]), .zlf_double_chirp(misc[3]), .zlf_transfer(), .zlf_desc_done(),
      .zlf_desc_phy_err(), .zlf_desc_more(), .zlf_desc_err_code(),
      .rx_fifo_has_frames(misc[4]), .sleep_request(misc[5]), .sleep_allow(),
      .rx_word_write(misc[6]), .rx_word_addr(cnt), .counter_at_threshold(at_threshold),
      .counters_freeze(freeze), .counters_clear(clr), .counters_step_strobe(step),
      .rx_frame_done(frame_done), .tx_queue_done(tx_done), .rx_idle_irq(rx_irq),
      .tx_idle_irq(tx_irq), .rx_descriptor_interrupt(desc_irq), .dma_observe_select(),
      .misc_observe_select(), .sleep_clk_tick(sleep_tick), .core_clock_stopped(clock_stopped));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // datapath side inputs wander so the combinational outputs see many values
   always @(posedge clk) begin
      cnt    <= cnt + 32'h1;
      tx_len <= cnt[15:0];
      q_req  <= cnt[9:0];
      misc   <= cnt[10:3];
      if (rx_irq === 1'b1) rx_hits++;
      if (tx_irq === 1'b1) tx_hits++;
      if (desc_irq === 1'b1) desc_hits++;
   end
   task automatic pulse(input logic rx, input logic [9:0] tx);
      @(posedge clk);
      frame_done <= rx;
      tx_done    <= tx;
      @(posedge clk);
      frame_done <= 1'b0;
      tx_done    <= 10'h000;
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         host.rd(rows[i].a, rdv);
         if (rows[i].r !== 32'hx) `CHK("reset value", rows[i].r, rdv)
         host.wr(rows[i].a, rows[i].w);
         host.rd(rows[i].a, rdv);
         `CHK("readback", rows[i].e, rdv)
      end
      irq_pending <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK("irq enabled", 1'b1, irq_out)
      host.wr(8'h24, 32'h0);
      repeat (4) @(posedge clk);
      `CHK("irq gated", 1'b0, irq_out)
      at_threshold <= 1'b1;
      host.wr(8'h40, 32'he);
      #1;
      `CHK("step pulse", 1'b1, step)
      @(posedge clk);
      #1;
      `CHK("step ends", 1'b0, step)
      `CHK("freeze", 1'b1, freeze)
      `CHK("clear", 1'b1, clr)
      host.rd(8'h40, rdv);
      `CHK("stats", 32'h7, rdv)
      host.wr(8'h54, 32'h2);
      pulse(1'b1, 10'h000);
      pulse(1'b1, 10'h000);
      repeat (3) @(posedge clk);
      `CHK("count early", 0, desc_hits)
      pulse(1'b1, 10'h000);
      repeat (3) @(posedge clk);
      `CHK("count hit", 1, desc_hits)
      host.wr(8'h48, 32'h3);
      pulse(1'b1, 10'h000);
      repeat (6) @(posedge clk);
      `CHK("rx idle early", 0, rx_hits)
      repeat (30) @(posedge clk);
      `CHK("rx idle fired", 1, rx_hits)
      host.wr(8'h4c, 32'h403);
      pulse(1'b0, 10'h001);
      repeat (12) pulse(1'b0, 10'h002);
      `CHK("tx masked", 1, tx_hits)
      pulse(1'b0, 10'h001);
      repeat (40) @(posedge clk);
      `CHK("tx idle fired", 2, tx_hits)
      host.wr(8'h44, 32'h0);
      pulse(1'b1, 10'h000);
      repeat (60) @(posedge clk);
      `CHK("prescale off", 1, rx_hits)
      host.wr(8'h34, 32'h08);
      repeat (64) @(posedge clk);
      host.rd(8'h34, rdv);
      `CHK("chirp policy", 32'h08, rdv)
      host.wr(8'h34, 32'h10);
      repeat (64) @(posedge clk);
      host.rd(8'h34, rdv);
      `CHK("all zero frames", 32'h10, rdv)
      for (int k = 0; k < 2; k++) begin
         clock_stopped <= k[0];
         repeat (256) begin
            repeat (2) @(posedge clk);
            sleep_tick <= 1'b1;
            repeat (2) @(posedge clk);
            sleep_tick <= 1'b0;
         end
         repeat (4) @(posedge clk);
         host.rd(8'h5c, rdv);
         `CHK("awake count", {31'h0, !k[0]}, rdv)
         host.rd(8'h60, rdv);
         `CHK("asleep count", {31'h0, k[0]}, rdv)
      end
      complete_run();
   end
endmodule
`default_nettype wire
